// ### rtl/cdps_top.sv
`timescale 1ns/1ps
module cdps_top (
    input  wire logic       sys_clk_in,
    input  wire logic       nrst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_en_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_rd_en_in,
    output logic [7:0]      reg_rdata_out,
    output logic            reg_rvalid_out,
    input  wire logic       extended_detect_select_in,
    input  wire logic [2:0] charger_kind_mask_in,
    input  wire logic       auto_detect_start_in,
    input  wire logic       detect_disable_in,
    input  wire logic [1:0] detect_class_in,
    input  wire logic [2:0] host_power_en_in,
    input  wire logic [2:0] port_charging_active_in,
    output logic            detect_busy_out,
    output logic [2:0]      port_charge_enable_out,
    output logic [2:0]      overcurrent_report_out,
    output logic [2:0]      port_power_on_status_out
);
    import cdps_pkg::*;

    typedef struct packed {
        logic [2:0] detected_charger_kind;
        logic       detect_done_flag;
        logic       charger_found_low;
        logic       manual_detect_trigger;
        logic [2:0] port_charge_enable;
        logic [2:0] overcurrent_report;
        logic [7:0] rdata;
        logic       rvalid;
        logic       busy;
    } cdps_top_s;

    cdps_top_s  st_reg;
    cdps_top_s  st_next;

    logic       seq_start;
    logic       seq_busy;
    logic       seq_done;
    logic [1:0] seq_class;
    logic       wr_result;
    logic       wr_trigger;
    logic       wr_found_high;
    logic [2:0] pwr_status;
    logic [7:0] result_view;

    function automatic logic [2:0] cdps_encode_kind(input logic [1:0] cls,
                                                   input logic       ext);
        logic [2:0] kind;
        kind = KIND_INCOMPLETE;
        case (cls)
            CLASS_DCP: kind = ext ? KIND_DCP : KIND_DCP_OR_CDP;
            CLASS_CDP: kind = ext ? KIND_CDP : KIND_DCP_OR_CDP;
            CLASS_SDP: kind = KIND_SDP;
            default:   kind = KIND_INCOMPLETE;
        endcase
        return kind;
    endfunction

    function automatic logic cdps_unmasked_charger(input logic [1:0] cls,
                                                  input logic [2:0] mask);
        logic hit;
        hit = 1'b0;
        case (cls)
            CLASS_DCP: hit = !mask[0];
            CLASS_CDP: hit = !mask[1];
            CLASS_SDP: hit = !mask[2];
            default:   hit = 1'b0;
        endcase
        return hit;
    endfunction

    assign wr_result     = reg_wr_en_in && (reg_addr_in == ADDR_CHARGER_RESULT);
    assign wr_trigger    = wr_result && reg_wdata_in[TRIGGER_BIT];
    assign wr_found_high = wr_result && reg_wdata_in[FOUND_LOW_BIT];
    // Manual and automatic starts share one sequencer; a manual write restarts it
    assign seq_start     = wr_trigger || auto_detect_start_in;

    assign result_view = {st_reg.detected_charger_kind, st_reg.detect_done_flag,
                          2'b00, st_reg.charger_found_low, st_reg.manual_detect_trigger};

    always_comb begin
        st_next        = st_reg;
        st_next.busy   = seq_busy || seq_start;
        st_next.rvalid = reg_rd_en_in;

        // Disabled detection overrides any stale result every cycle
        if (detect_disable_in) begin
            st_next.detected_charger_kind = KIND_DISABLED;
        end else if (seq_done) begin
            st_next.detected_charger_kind =
                cdps_encode_kind(seq_class, extended_detect_select_in);
        end

        // Completion wins over a trigger landing in the same cycle
        if (seq_done) begin
            st_next.detect_done_flag = 1'b1;
        end else if (wr_trigger) begin
            st_next.detect_done_flag = 1'b0;
        end

        // A fresh detection result wins over a software force-high
        if (seq_done) begin
            st_next.charger_found_low =
                !cdps_unmasked_charger(seq_class, charger_kind_mask_in);
        end else if (wr_found_high) begin
            st_next.charger_found_low = 1'b1;
        end

        // A new write wins over completion so a back-to-back start is not lost
        if (wr_trigger) begin
            st_next.manual_detect_trigger = 1'b1;
        end else if (seq_done) begin
            st_next.manual_detect_trigger = 1'b0;
        end

        if (reg_wr_en_in && reg_addr_in == ADDR_PORT_CHARGE_EN) begin
            st_next.port_charge_enable = reg_wdata_in[PORT_MSB:PORT_LSB];
        end
        if (reg_wr_en_in && reg_addr_in == ADDR_OVERCURRENT) begin
            st_next.overcurrent_report = reg_wdata_in[PORT_MSB:PORT_LSB];
        end

        st_next.rdata = 8'h00;
        if (reg_rd_en_in) begin
            // Reserved bits and unmapped offsets read back as zero
            case (reg_addr_in)
                ADDR_CHARGER_RESULT: st_next.rdata = result_view;
                ADDR_PORT_POWER:     st_next.rdata = {4'h0, pwr_status, 1'b0};
                ADDR_PORT_CHARGE_EN: st_next.rdata = {4'h0, st_reg.port_charge_enable, 1'b0};
                ADDR_OVERCURRENT:    st_next.rdata = {4'h0, st_reg.overcurrent_report, 1'b0};
                default:             st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            st_reg <= '{detected_charger_kind: RST_CHARGER_RESULT[KIND_MSB:KIND_LSB],
                        detect_done_flag:      RST_CHARGER_RESULT[DONE_BIT],
                        charger_found_low:     RST_CHARGER_RESULT[FOUND_LOW_BIT],
                        manual_detect_trigger: RST_CHARGER_RESULT[TRIGGER_BIT],
                        port_charge_enable:    RST_PORT_CHARGE_EN[PORT_MSB:PORT_LSB],
                        overcurrent_report:    RST_OVERCURRENT[PORT_MSB:PORT_LSB],
                        rdata:                 8'h00,
                        rvalid:                1'b0,
                        busy:                  1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    cdps_seq u_seq (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .start_in   (seq_start),
        .disable_in (detect_disable_in),
        .class_in   (detect_class_in),
        .busy_out   (seq_busy),
        .done_out   (seq_done),
        .class_out  (seq_class)
    );

    cdps_pwr u_pwr (
        .sys_clk_in         (sys_clk_in),
        .nrst_in            (nrst_in),
        .host_power_en_in   (host_power_en_in),
        .charge_en_in       (st_reg.port_charge_enable),
        .charging_active_in (port_charging_active_in),
        .overcurrent_in     (st_reg.overcurrent_report),
        .power_status_out   (pwr_status)
    );

    assign reg_rdata_out            = st_reg.rdata;
    assign reg_rvalid_out           = st_reg.rvalid;
    assign detect_busy_out          = st_reg.busy;
    assign port_charge_enable_out   = st_reg.port_charge_enable;
    assign overcurrent_report_out   = st_reg.overcurrent_report;
    assign port_power_on_status_out = pwr_status;

    property p_disabled_kind;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        detect_disable_in |=> st_reg.detected_charger_kind == KIND_DISABLED;
    endproperty
    a_disabled_kind: assert property (p_disabled_kind)
        else $error("kind not 111 while detection disabled");

    property p_ext_cdp;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        seq_done && !detect_disable_in && extended_detect_select_in
            && seq_class == CLASS_CDP
        |=> st_reg.detected_charger_kind == KIND_CDP;
    endproperty
    a_ext_cdp: assert property (p_ext_cdp)
        else $error("extended encoding of charging port wrong");

    property p_plain_cdp;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        seq_done && !detect_disable_in && !extended_detect_select_in
            && seq_class != CLASS_SDP && seq_class != CLASS_NONE
        |=> st_reg.detected_charger_kind == KIND_DCP_OR_CDP;
    endproperty
    a_plain_cdp: assert property (p_plain_cdp)
        else $error("plain encoding of charger not 001");

    property p_done_cycle;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        wr_trigger && !seq_done && !detect_disable_in
        |=> !st_reg.detect_done_flag ##1 !st_reg.detect_done_flag;
    endproperty
    a_done_cycle: assert property (p_done_cycle)
        else $error("done flag not cleared by manual trigger");

    property p_found_low;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        seq_done && cdps_unmasked_charger(seq_class, charger_kind_mask_in)
        |=> !st_reg.charger_found_low;
    endproperty
    a_found_low: assert property (p_found_low)
        else $error("unmasked charger not reported low");

    property p_force_high;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        wr_found_high && !seq_done |=> st_reg.charger_found_low;
    endproperty
    a_force_high: assert property (p_force_high)
        else $error("write of 1 did not force found bit high");

    property p_trigger_runs;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        wr_trigger && !detect_disable_in
        |=> st_reg.manual_detect_trigger && detect_busy_out;
    endproperty
    a_trigger_runs: assert property (p_trigger_runs)
        else $error("manual trigger did not start detection");

    property p_trigger_clears;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        st_reg.manual_detect_trigger && seq_done && !wr_trigger
        |=> !st_reg.manual_detect_trigger;
    endproperty
    a_trigger_clears: assert property (p_trigger_clears)
        else $error("trigger bit not cleared at completion");

    property p_reserved_zero;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        reg_rd_en_in && reg_addr_in == ADDR_CHARGER_RESULT
        |=> reg_rvalid_out && reg_rdata_out[3:2] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits of result register not zero");

    property p_kind_sdp;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        seq_done && !detect_disable_in && seq_class == CLASS_SDP
        |=> st_reg.detected_charger_kind == KIND_SDP;
    endproperty
    a_kind_sdp: assert property (p_kind_sdp)
        else $error("standard port kind not 011");

    property p_kind_none;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        seq_done && !detect_disable_in && seq_class == CLASS_NONE
        |=> st_reg.detected_charger_kind == KIND_INCOMPLETE;
    endproperty
    a_kind_none: assert property (p_kind_none)
        else $error("no-charger kind not 000");

    property p_power_read;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        reg_rd_en_in && reg_addr_in == ADDR_PORT_POWER
        |=> reg_rdata_out == {4'h0, $past(port_power_on_status_out), 1'b0};
    endproperty
    a_power_read: assert property (p_power_read)
        else $error("port power read does not match status");

    property p_charge_en_write;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        reg_wr_en_in && reg_addr_in == ADDR_PORT_CHARGE_EN
        |=> {4'h0, port_charge_enable_out, 1'b0} == ($past(reg_wdata_in) & 8'h0e);
    endproperty
    a_charge_en_write: assert property (p_charge_en_write)
        else $error("charge enable write not taken");

    property p_ocs_write;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        reg_wr_en_in && reg_addr_in == ADDR_OVERCURRENT
        |=> {4'h0, overcurrent_report_out, 1'b0} == ($past(reg_wdata_in) & 8'h0e);
    endproperty
    a_ocs_write: assert property (p_ocs_write)
        else $error("over-current write not taken or reserved bits kept");

endmodule

// ### pkg/cdps_pkg.sv
package cdps_pkg;

    // Register offsets on the serial management port
    localparam logic [7:0] ADDR_PORT_CHARGE_EN  = 8'hd0;
    localparam logic [7:0] ADDR_CHARGER_RESULT  = 8'he2;
    localparam logic [7:0] ADDR_PORT_POWER      = 8'he5;
    localparam logic [7:0] ADDR_OVERCURRENT     = 8'he6;

    // Reset values
    localparam logic [7:0] RST_CHARGER_RESULT   = 8'h02;
    localparam logic [7:0] RST_PORT_POWER       = 8'h00;
    localparam logic [7:0] RST_PORT_CHARGE_EN   = 8'h00;
    localparam logic [7:0] RST_OVERCURRENT      = 8'h00;

    // Field positions of the charger detect result register
    localparam int KIND_MSB                     = 7;
    localparam int KIND_LSB                     = 5;
    localparam int DONE_BIT                     = 4;
    localparam int FOUND_LOW_BIT                = 1;
    localparam int TRIGGER_BIT                  = 0;

    // Per-port fields sit at bits 3:1 of the port registers
    localparam int PORT_LSB                     = 1;
    localparam int PORT_MSB                     = 3;
    localparam int NUM_PORTS                    = 3;

    // Charger kind codes
    localparam logic [2:0] KIND_INCOMPLETE      = 3'h0;
    localparam logic [2:0] KIND_DCP             = 3'h1;
    localparam logic [2:0] KIND_DCP_OR_CDP      = 3'h1;
    localparam logic [2:0] KIND_CDP             = 3'h2;
    localparam logic [2:0] KIND_SDP             = 3'h3;
    localparam logic [2:0] KIND_DISABLED        = 3'h7;

    // Class reported by the detection front end
    localparam logic [1:0] CLASS_NONE           = 2'h0;
    localparam logic [1:0] CLASS_DCP            = 2'h1;
    localparam logic [1:0] CLASS_CDP            = 2'h2;
    localparam logic [1:0] CLASS_SDP            = 2'h3;

    // Detection sequence length, a least time so it rounds up
    localparam int CLK_PERIOD_NS                = 5;
    localparam int DETECT_TIME_NS               = 1000;
    localparam int DETECT_CYCLES_INT            =
        (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] DETECT_CYCLES        = 8'(DETECT_CYCLES_INT);

endpackage

// ### rtl/cdps_seq.sv
`timescale 1ns/1ps
module cdps_seq (
    input  wire logic       sys_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       start_in,
    input  wire logic       disable_in,
    input  wire logic [1:0] class_in,
    output logic            busy_out,
    output logic            done_out,
    output logic [1:0]      class_out
);
    import cdps_pkg::*;

    typedef enum logic [1:0] {
        CDPS_IDLE = 2'b01,
        CDPS_RUN  = 2'b10
    } cdps_seq_state_e;

    typedef struct packed {
        cdps_seq_state_e state;
        logic [7:0]      cnt;
        logic            done;
        logic [1:0]      cls;
    } cdps_seq_s;

    cdps_seq_s st_reg;
    cdps_seq_s st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        case (st_reg.state)
            CDPS_IDLE: begin
                if (start_in && disable_in) begin
                    // Nothing to run; finish at once so a trigger still clears
                    st_next.done = 1'b1;
                    st_next.cls  = CLASS_NONE;
                end else if (start_in) begin
                    st_next.state = CDPS_RUN;
                    st_next.cnt   = DETECT_CYCLES;
                end
            end
            CDPS_RUN: begin
                if (disable_in) begin
                    st_next.state = CDPS_IDLE;
                    st_next.done  = 1'b1;
                    st_next.cls   = CLASS_NONE;
                end else if (start_in) begin
                    st_next.cnt = DETECT_CYCLES;
                end else if (st_reg.cnt == 8'h01) begin
                    st_next.state = CDPS_IDLE;
                    st_next.done  = 1'b1;
                    st_next.cls   = class_in;
                end else begin
                    st_next.cnt = st_reg.cnt - 8'h01;
                end
            end
            default: begin
                st_next.state = CDPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            st_reg <= '{state: CDPS_IDLE, cnt: 8'h00, done: 1'b0, cls: 2'h0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy_out  = (st_reg.state == CDPS_RUN);
    assign done_out  = st_reg.done;
    assign class_out = st_reg.cls;

endmodule

// ### rtl/cdps_pwr.sv
`timescale 1ns/1ps
module cdps_pwr (
    input  wire logic       sys_clk_in,
    input  wire logic       nrst_in,
    input  wire logic [2:0] host_power_en_in,
    input  wire logic [2:0] charge_en_in,
    input  wire logic [2:0] charging_active_in,
    input  wire logic [2:0] overcurrent_in,
    output logic [2:0]      power_status_out
);
    import cdps_pkg::*;

    typedef struct packed {
        logic [2:0] status;
    } cdps_pwr_s;

    cdps_pwr_s st_reg;
    cdps_pwr_s st_next;

    always_comb begin
        st_next = st_reg;
        for (int i = 0; i < NUM_PORTS; i++) begin
            // Charging mode or an over-current report both hide host power
            st_next.status[i] = host_power_en_in[i]
                              & ~(charge_en_in[i] & charging_active_in[i])
                              & ~overcurrent_in[i];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            st_reg <= '{status: RST_PORT_POWER[PORT_MSB:PORT_LSB]};
        end else begin
            st_reg <= st_next;
        end
    end

    assign power_status_out = st_reg.status;

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_chk
            property p_ocs_clears;
                @(posedge sys_clk_in) disable iff (!nrst_in)
                overcurrent_in[g] |=> !power_status_out[g];
            endproperty
            a_ocs_clears: assert property (p_ocs_clears)
                else $error("port power status stayed set under over-current");

            property p_host_on;
                @(posedge sys_clk_in) disable iff (!nrst_in)
                host_power_en_in[g] && !overcurrent_in[g]
                    && !(charge_en_in[g] && charging_active_in[g])
                |=> power_status_out[g];
            endproperty
            a_host_on: assert property (p_host_on)
                else $error("port power status not set while host powers port");
        end
    endgenerate

endmodule

// ### sim/cdps_host_model.sv
`timescale 1ns/1ps
module cdps_host_model (
    input  wire logic       sys_clk_in,
    input  wire logic       hub_operating_in,
    input  wire logic [7:0] reg_rdata_in,
    input  wire logic       reg_rvalid_in,
    output logic [7:0]      reg_addr_out,
    output logic            reg_wr_en_out,
    output logic [7:0]      reg_wdata_out,
    output logic            reg_rd_en_out
);
    import cdps_pkg::*;

    initial begin
        reg_addr_out  = 8'h00;
        reg_wr_en_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_en_out = 1'b0;
    end

    // Tasks are entered just after an edge and end with one idle edge, so that
    // back-to-back calls never drop and raise a strobe in the same time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] w;
        w = d;
        // Software never fires the manual trigger while the hub is running
        if (a == ADDR_CHARGER_RESULT && hub_operating_in) w[TRIGGER_BIT] = 1'b0;
        reg_addr_out  = a;
        reg_wdata_out = w;
        reg_wr_en_out = 1'b1;
        @(posedge sys_clk_in);
        #1;
        reg_wr_en_out = 1'b0;
        @(posedge sys_clk_in);
        #1;
    endtask

    // Read data and valid stand one cycle, so they are taken right after the edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        reg_addr_out  = a;
        reg_rd_en_out = 1'b1;
        @(posedge sys_clk_in);
        #1;
        reg_rd_en_out = 1'b0;
        d = reg_rdata_in;
        v = reg_rvalid_in;
        @(posedge sys_clk_in);
        #1;
    endtask
endmodule

// ### sim/cdps_tb_top.sv
`timescale 1ns/1ps
module cdps_tb_top;
    import cdps_pkg::*;

    logic       sys_clk_in = 1'b0;
    logic       nrst_in = 1'b0;
    logic [7:0] addr, wdata, rdata, d;
    logic       wr_en, rd_en, rvalid, v, busy;
    logic       ext = 1'b0, auto_start = 1'b0, dis = 1'b0;
    logic [2:0] mask = 3'h0, host_en = 3'h0, chg_act = 3'h0;
    logic [1:0] cls = 2'h0;
    logic [2:0] bc_out, oc_out, pwr_out;
    logic [7:0] exp_e2;
    int         miscompares = 0;
    int         total_checks = 0;

    always #2.5 sys_clk_in = ~sys_clk_in;

    cdps_host_model u_host (
        .sys_clk_in      (sys_clk_in),
        .hub_operating_in(|host_en),
        .reg_rdata_in    (rdata),
        .reg_rvalid_in   (rvalid),
        .reg_addr_out    (addr),
        .reg_wr_en_out   (wr_en),
        .reg_wdata_out   (wdata),
        .reg_rd_en_out   (rd_en)
    );

    cdps_top u_dut (
        .sys_clk_in               (sys_clk_in),
        .nrst_in                  (nrst_in),
        .reg_addr_in              (addr),
        .reg_wr_en_in             (wr_en),
        .reg_wdata_in             (wdata),
        .reg_rd_en_in             (rd_en),
        .reg_rdata_out            (rdata),
        .reg_rvalid_out           (rvalid),
        .extended_detect_select_in(ext),
        .charger_kind_mask_in     (mask),
        .auto_detect_start_in     (auto_start),
        .detect_disable_in        (dis),
        .detect_class_in          (cls),
        .host_power_en_in         (host_en),
        .port_charging_active_in  (chg_act),
        .detect_busy_out          (busy),
        .port_charge_enable_out   (bc_out),
        .overcurrent_report_out   (oc_out),
        .port_power_on_status_out (pwr_out)
    );

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk3(input string name, input logic [2:0] e, input logic [2:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, d, v);
        chk8("read valid", 8'h01, {7'h00, v});
        chk8($sformatf("reg %h", a), e, d);
    endtask

    task automatic tick();
        @(posedge sys_clk_in);
        #1;
    endtask

    // Bounded wait for the sequencer, then time for the result to land
    task automatic wait_done();
        for (int i = 0; i < 400 && busy !== 1'b0; i++) tick();
        if (busy !== 1'b0) begin
            miscompares++;
            $display("[ERR] detect busy expected 0 seen %b", busy);
            test_done();
        end
        tick();
        tick();
    endtask

    function automatic logic [2:0] kind_of(input logic [1:0] c, input logic e);
        if (c == CLASS_CDP) return e ? KIND_CDP : KIND_DCP_OR_CDP;
        if (c == CLASS_DCP) return KIND_DCP;
        if (c == CLASS_SDP) return KIND_SDP;
        return KIND_INCOMPLETE;
    endfunction

    initial begin
        repeat (5) @(posedge sys_clk_in);
        #1;
        nrst_in = 1'b1;
        rd_chk(ADDR_CHARGER_RESULT, RST_CHARGER_RESULT);
        rd_chk(ADDR_PORT_POWER, RST_PORT_POWER);
        rd_chk(8'h10, 8'h00);
        u_host.wr(ADDR_PORT_CHARGE_EN, 8'hff);
        u_host.wr(ADDR_OVERCURRENT, 8'hff);
        u_host.wr(ADDR_PORT_POWER, 8'hff);
        u_host.wr(ADDR_CHARGER_RESULT, 8'hfc);
        rd_chk(ADDR_PORT_CHARGE_EN, 8'h0e);
        rd_chk(ADDR_OVERCURRENT, 8'h0e);
        rd_chk(ADDR_PORT_POWER, 8'h00);
        rd_chk(ADDR_CHARGER_RESULT, 8'h02);
        chk3("charge enable", 3'h7, bc_out);
        chk3("overcurrent", 3'h7, oc_out);
        // Port power: host enable, charging and over-current each gate a port
        host_en = 3'h7;
        u_host.wr(ADDR_OVERCURRENT, 8'h00);
        tick();
        rd_chk(ADDR_PORT_POWER, 8'h0e);
        chg_act = 3'h2;
        tick();
        rd_chk(ADDR_PORT_POWER, 8'h0a);
        // Charging hides power only while charge support is enabled
        u_host.wr(ADDR_PORT_CHARGE_EN, 8'h00);
        tick();
        rd_chk(ADDR_PORT_POWER, 8'h0e);
        chg_act = 3'h0;
        host_en = 3'h6;
        u_host.wr(ADDR_OVERCURRENT, 8'h08);
        tick();
        rd_chk(ADDR_PORT_POWER, 8'h04);
        chk3("power status", 3'h2, pwr_out);
        host_en = 3'h0;
        u_host.wr(ADDR_OVERCURRENT, 8'h00);
        // Manual runs over every class in both encodings
        exp_e2 = RST_CHARGER_RESULT;
        for (int e = 0; e < 2; e++) begin
            for (int c = 0; c < 4; c++) begin
                ext = e[0];
                cls = c[1:0];
                u_host.wr(ADDR_CHARGER_RESULT, 8'h01);
                rd_chk(ADDR_CHARGER_RESULT, {exp_e2[7:5], 3'b000, exp_e2[1], 1'b1});
                wait_done();
                exp_e2 = {kind_of(cls, ext), 1'b1, 2'b00, (cls == CLASS_NONE), 1'b0};
                rd_chk(ADDR_CHARGER_RESULT, exp_e2);
            end
        end
        u_host.wr(ADDR_CHARGER_RESULT, 8'h00);
        rd_chk(ADDR_CHARGER_RESULT, exp_e2);
        u_host.wr(ADDR_CHARGER_RESULT, 8'h02);
        exp_e2[FOUND_LOW_BIT] = 1'b1;
        rd_chk(ADDR_CHARGER_RESULT, exp_e2);
        // Masked charger kind does not count as found
        mask = 3'h2;
        cls = CLASS_CDP;
        u_host.wr(ADDR_CHARGER_RESULT, 8'h01);
        wait_done();
        rd_chk(ADDR_CHARGER_RESULT, 8'h52);
        // Automatic start, plain encoding
        mask = 3'h0;
        ext = 1'b0;
        cls = CLASS_DCP;
        auto_start = 1'b1;
        tick();
        auto_start = 1'b0;
        chk3("detect busy", 3'h1, {2'b00, busy});
        wait_done();
        rd_chk(ADDR_CHARGER_RESULT, 8'h30);
        dis = 1'b1;
        tick();
        u_host.rd(ADDR_CHARGER_RESULT, d, v);
        chk8("kind disabled", {5'h00, KIND_DISABLED}, {5'h00, d[7:5]});
        // A manual start with detection disabled finishes at once and self-clears
        u_host.wr(ADDR_CHARGER_RESULT, 8'h01);
        rd_chk(ADDR_CHARGER_RESULT, 8'hf2);
        test_done();
    end
endmodule
